//--- src/lvd_cfg.svh
// Purpose: Offsets, field positions, reset values and set codes of the level DAC register bank
// Assumes: Included by bare name from the design files and the testbench
// Notes: Definitions only
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

// ****************************************
// Bus register offsets (word index, adr[7:2])
// ****************************************
`define LVD_IDX_CMD 6'h00
`define LVD_IDX_RDBK 6'h01
`define LVD_IDX_CTRL 6'h02

// ****************************************
// Command word fields
// ****************************************
`define LVD_CMD_RD_BIT 28
`define LVD_CMD_MASK_HI 27
`define LVD_CMD_MASK_LO 24
`define LVD_CMD_TYPE_HI 23
`define LVD_CMD_TYPE_LO 22
`define LVD_CMD_ADDR_HI 21
`define LVD_CMD_ADDR_LO 16
`define LVD_RDBK_ERR_BIT 16

// ****************************************
// Register-set address codes
// ****************************************
`define LVD_SET_OFFSET_DAC 6'h00
`define LVD_SET_FIN_BASE 6'h08
`define LVD_SET_CPL_BASE 6'h10
`define LVD_SET_CPH_BASE 6'h18
`define LVD_SET_CLL_BASE 6'h20
`define LVD_SET_CLH_BASE 6'h28
`define LVD_SETS_PER_RANGED 6'h06
`define LVD_SETS_PER_CLAMP 6'h02

// ****************************************
// Storage slot layout
// ****************************************
`define LVD_SLOT_CPL 5'h06
`define LVD_SLOT_CPH 5'h0c
`define LVD_SLOT_CLL_CUR 5'h12
`define LVD_SLOT_CLL_VOLT 5'h13
`define LVD_SLOT_CLH_CUR 5'h14
`define LVD_SLOT_CLH_VOLT 5'h15
`define LVD_SLOT_FIN_VOLT 5'h05
`define LVD_RANGE_MAX 3'h4

// ****************************************
// Reset values and correction constants
// ****************************************
`define LVD_RST_INPUT 16'h0000
`define LVD_RST_GAIN 16'hfffe
`define LVD_RST_OFFS 16'h8000
`define LVD_RST_CODE 16'h0000
`define LVD_RST_CTRL 16'h0000
`define LVD_CORR_MID 18'h08000
`define LVD_GAIN_BIAS 17'h00002

`endif

//--- src/lvd_pkg.sv
// Purpose: Shared types of the level DAC register bank
// Assumes: lvd_cfg.svh holds the numbers
// Notes: Types only
package lvd_pkg;
	// ****************************************
	// Register-type field encoding
	// ****************************************
	typedef enum logic [1:0] {
		LVD_TYPE_SYS = 2'h0,
		LVD_TYPE_GAIN = 2'h1,
		LVD_TYPE_OFFS = 2'h2,
		LVD_TYPE_INPUT = 2'h3
	} lvd_rtype_t;

	// Storage slot index of one calibration trio
	typedef logic [4:0] lvd_slot_t;
endpackage

//--- src/lvd_corr.sv
// Purpose: Gain and offset correction of one DAC input code
// Assumes: Gain holds 15 significant bits with bit 0 zero
// Notes: Result saturates to the 16-bit code range
`timescale 1ns/10ps
`include "lvd_cfg.svh"

module lvd_corr import lvd_pkg::*; (
	input wire logic [15:0] inCode,
	input wire logic [15:0] gainCoef,
	input wire logic [15:0] offsCoef,
	output logic [15:0] outCode
);
	// ****************************************
	// Scaled code plus offset, then clamp
	// ****************************************
	logic [32:0] prod; // Code times gain plus bias
	logic [17:0] sum; // Offset-shifted sum

	always_comb begin
		prod = {17'h00000, inCode} * {16'h0000, {1'h0, gainCoef} + `LVD_GAIN_BIAS};
		sum = {2'h0, prod[31:16]} + {2'h0, offsCoef} - `LVD_CORR_MID;
		// Below zero clamps low, above full scale clamps high
		if (sum[17]) begin
			outCode = 16'h0000;
		end else if (sum[16]) begin
			outCode = 16'hffff;
		end else begin
			outCode = sum[15:0];
		end
	end
endmodule

//--- src/level_dac_register_addressing.sv
// Purpose: Calibration register sets behind the level DACs of four channels
// Assumes: Classic Wishbone slave, one clock, synchronous reset
// Notes: Command word written to CMD drives writes and readbacks
`timescale 1ns/10ps
`include "lvd_cfg.svh"

// Summary of operation
// - Force and comparator DACs: trio per range
// - Clamp DACs have exactly two trios
// - Gain and offset coefficients are volatile
// - Only input writes recompute corrected code
// - One shared offset DAC, mask selected
// - Offset DAC has input register only
// - Readback uses the write address decode
// - Forcing voltage loads current clamp sets
// - Forcing current loads voltage clamp sets
// - Force-current sets start at address 001000
// - Type 00 system, 01 gain, 10 offset, 11 input
// - Gain 15 upper bits, others 16 bits
module level_dac_register_addressing import lvd_pkg::*; (
	input wire logic mclk,
	input wire logic srst,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [7:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatI,
	output logic [31:0] wbDatO,
	output logic wbAck,
	output logic [63:0] finCode,
	output logic [63:0] cplCode,
	output logic [63:0] cphCode,
	output logic [63:0] cllCode,
	output logic [63:0] clhCode,
	output logic [15:0] offsetDacCode
);
	// ****************************************
	// Functions
	// ****************************************

	// Set address to {valid, slot}
	function automatic logic [5:0] decodeSet(input logic [5:0] a);
		logic [5:0] r;
		r = 6'h00;
		if (a >= `LVD_SET_FIN_BASE && a < `LVD_SET_FIN_BASE + `LVD_SETS_PER_RANGED) begin
			r = {1'h1, 5'(a - `LVD_SET_FIN_BASE)};
		end else if (a >= `LVD_SET_CPL_BASE && a < `LVD_SET_CPL_BASE + `LVD_SETS_PER_RANGED) begin
			r = {1'h1, 5'(a - `LVD_SET_CPL_BASE) + `LVD_SLOT_CPL};
		end else if (a >= `LVD_SET_CPH_BASE && a < `LVD_SET_CPH_BASE + `LVD_SETS_PER_RANGED) begin
			r = {1'h1, 5'(a - `LVD_SET_CPH_BASE) + `LVD_SLOT_CPH};
		end else if (a >= `LVD_SET_CLL_BASE && a < `LVD_SET_CLL_BASE + `LVD_SETS_PER_CLAMP) begin
			r = {1'h1, 5'(a - `LVD_SET_CLL_BASE) + `LVD_SLOT_CLL_CUR};
		end else if (a >= `LVD_SET_CLH_BASE && a < `LVD_SET_CLH_BASE + `LVD_SETS_PER_CLAMP) begin
			r = {1'h1, 5'(a - `LVD_SET_CLH_BASE) + `LVD_SLOT_CLH_CUR};
		end
		return r;
	endfunction

	// Active range slot from a control nibble: {forceCurrent, range[2:0]}
	function automatic lvd_slot_t rangeSlot(input logic [3:0] n);
		lvd_slot_t s;
		s = `LVD_SLOT_FIN_VOLT;
		if (n[3]) begin
			s = (n[2:0] > `LVD_RANGE_MAX) ? 5'(`LVD_RANGE_MAX) : 5'(n[2:0]);
		end
		return s;
	endfunction

	// ****************************************
	// Storage
	// ****************************************
	logic [15:0] inReg_r [4][22]; // Input code per channel and set
	logic [15:0] gainReg_r [4][22]; // Volatile gain coefficients
	logic [15:0] offsReg_r [4][22]; // Volatile offset coefficients
	logic [15:0] corrReg_r [4][22]; // Corrected codes
	logic [15:0] offsetDac_r; // Shared offset DAC input
	logic [15:0] ctrl_r; // Per-channel force mode and range
	logic [15:0] rdbkData_r; // Last readback value
	logic rdbkErr_r; // Last command had no target
	logic [31:0] cmd_r; // Last command word
	logic ack_r; // Bus acknowledge
	logic [31:0] datO_r; // Bus read data
	logic [15:0] finCode_r [4]; // Registered DAC outputs
	logic [15:0] cplCode_r [4];
	logic [15:0] cphCode_r [4];
	logic [15:0] cllCode_r [4];
	logic [15:0] clhCode_r [4];

	// ****************************************
	// Command decode
	// ****************************************
	logic busReq; // New access this cycle
	logic cmdAcc; // Full-word write to CMD
	logic doWr; // Register write command
	logic doRd; // Readback command
	logic [3:0] cmdMask; // Channel select mask
	lvd_rtype_t cmdType; // Register type
	logic [5:0] cmdAddr; // Register-set address
	logic [15:0] cmdData; // Data field
	logic [5:0] setDec; // Decoded set
	lvd_slot_t cmdSlot; // Addressed slot
	logic offHit; // Targets the shared offset DAC
	logic trioHit; // Targets a calibration trio
	logic [1:0] rdCh; // Channel that answers a readback
	logic [15:0] corrOut [4]; // Correction results

	assign busReq = wbCyc && wbStb && !ack_r;
	assign cmdAcc = busReq && wbWe && wbAdr[7:2] == `LVD_IDX_CMD && wbSel == 4'hf;
	assign doWr = cmdAcc && !wbDatI[`LVD_CMD_RD_BIT];
	assign doRd = cmdAcc && wbDatI[`LVD_CMD_RD_BIT];
	assign cmdMask = wbDatI[`LVD_CMD_MASK_HI:`LVD_CMD_MASK_LO];
	assign cmdType = lvd_rtype_t'(wbDatI[`LVD_CMD_TYPE_HI:`LVD_CMD_TYPE_LO]);
	assign cmdAddr = wbDatI[`LVD_CMD_ADDR_HI:`LVD_CMD_ADDR_LO];
	assign cmdData = wbDatI[15:0];
	assign setDec = decodeSet(cmdAddr);
	assign cmdSlot = setDec[4:0];
	// Offset DAC answers only at input type with some channel selected
	assign offHit = cmdAddr == `LVD_SET_OFFSET_DAC && cmdType == LVD_TYPE_INPUT
		&& cmdMask != 4'h0;
	// Type 00 belongs to other register groups and has no target here
	assign trioHit = setDec[5] && cmdType != LVD_TYPE_SYS && cmdMask != 4'h0;

	// Lowest selected channel answers a readback
	always_comb begin
		rdCh = 2'h0;
		for (int ch = 3; ch >= 0; ch--) begin
			if (cmdMask[ch]) begin
				rdCh = 2'(ch);
			end
		end
	end

	// ****************************************
	// Correction per channel
	// ****************************************
	for (genvar g = 0; g < 4; g++) begin : gCorr
		lvd_corr uCorr (
			.inCode(cmdData),
			.gainCoef(gainReg_r[g][cmdSlot]),
			.offsCoef(offsReg_r[g][cmdSlot]),
			.outCode(corrOut[g])
		);
	end

	// ****************************************
	// Calibration trio storage
	// ****************************************

	// Input, gain and offset registers of every selected channel
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int ch = 0; ch < 4; ch++) begin
				for (int s = 0; s < 22; s++) begin
					inReg_r[ch][s] <= `LVD_RST_INPUT;
					gainReg_r[ch][s] <= `LVD_RST_GAIN;
					offsReg_r[ch][s] <= `LVD_RST_OFFS;
				end
			end
		end else if (doWr && trioHit) begin
			for (int ch = 0; ch < 4; ch++) begin
				if (cmdMask[ch]) begin
					unique case (cmdType)
						LVD_TYPE_GAIN: begin
							gainReg_r[ch][cmdSlot] <= {cmdData[15:1], 1'h0};
						end
						LVD_TYPE_OFFS: begin
							offsReg_r[ch][cmdSlot] <= cmdData;
						end
						LVD_TYPE_INPUT: begin
							inReg_r[ch][cmdSlot] <= cmdData;
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// Corrected codes change only when an input register is loaded
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int ch = 0; ch < 4; ch++) begin
				for (int s = 0; s < 22; s++) begin
					corrReg_r[ch][s] <= `LVD_RST_CODE;
				end
			end
		end else if (doWr && trioHit && cmdType == LVD_TYPE_INPUT) begin
			for (int ch = 0; ch < 4; ch++) begin
				if (cmdMask[ch]) begin
					corrReg_r[ch][cmdSlot] <= corrOut[ch];
				end
			end
		end
	end

	// Shared offset DAC input
	always_ff @(posedge mclk) begin
		if (srst) begin
			offsetDac_r <= `LVD_RST_CODE;
		end else if (doWr && offHit) begin
			offsetDac_r <= cmdData;
		end
	end

	// ****************************************
	// DAC outputs
	// ****************************************

	// Active range set drives force and comparators; clamps follow force mode
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int ch = 0; ch < 4; ch++) begin
				finCode_r[ch] <= `LVD_RST_CODE;
				cplCode_r[ch] <= `LVD_RST_CODE;
				cphCode_r[ch] <= `LVD_RST_CODE;
				cllCode_r[ch] <= `LVD_RST_CODE;
				clhCode_r[ch] <= `LVD_RST_CODE;
			end
		end else begin
			for (int ch = 0; ch < 4; ch++) begin
				finCode_r[ch] <= corrReg_r[ch][rangeSlot(ctrl_r[ch*4 +: 4])];
				cplCode_r[ch] <= corrReg_r[ch][rangeSlot(ctrl_r[ch*4 +: 4]) + `LVD_SLOT_CPL];
				cphCode_r[ch] <= corrReg_r[ch][rangeSlot(ctrl_r[ch*4 +: 4]) + `LVD_SLOT_CPH];
				if (ctrl_r[ch*4 + 3]) begin
					cllCode_r[ch] <= corrReg_r[ch][`LVD_SLOT_CLL_VOLT];
					clhCode_r[ch] <= corrReg_r[ch][`LVD_SLOT_CLH_VOLT];
				end else begin
					cllCode_r[ch] <= corrReg_r[ch][`LVD_SLOT_CLL_CUR];
					clhCode_r[ch] <= corrReg_r[ch][`LVD_SLOT_CLH_CUR];
				end
			end
		end
	end

	for (genvar g = 0; g < 4; g++) begin : gOut
		assign finCode[g*16 +: 16] = finCode_r[g];
		assign cplCode[g*16 +: 16] = cplCode_r[g];
		assign cphCode[g*16 +: 16] = cphCode_r[g];
		assign cllCode[g*16 +: 16] = cllCode_r[g];
		assign clhCode[g*16 +: 16] = clhCode_r[g];
	end
	assign offsetDacCode = offsetDac_r;

	// ****************************************
	// Command, readback and control registers
	// ****************************************

	// Last command and its target status; readback decodes like a write
	always_ff @(posedge mclk) begin
		if (srst) begin
			cmd_r <= 32'h00000000;
			rdbkData_r <= 16'h0000;
			rdbkErr_r <= 1'h0;
		end else if (cmdAcc) begin
			cmd_r <= wbDatI;
			rdbkErr_r <= !(offHit || trioHit);
			if (doRd) begin
				if (offHit) begin
					rdbkData_r <= offsetDac_r;
				end else if (trioHit) begin
					unique case (cmdType)
						LVD_TYPE_GAIN: rdbkData_r <= gainReg_r[rdCh][cmdSlot];
						LVD_TYPE_OFFS: rdbkData_r <= offsReg_r[rdCh][cmdSlot];
						default: rdbkData_r <= inReg_r[rdCh][cmdSlot];
					endcase
				end else begin
					rdbkData_r <= 16'h0000;
				end
			end
		end
	end

	// Control register, byte lanes 0 and 1
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_r <= `LVD_RST_CTRL;
		end else if (busReq && wbWe && wbAdr[7:2] == `LVD_IDX_CTRL) begin
			if (wbSel[0]) begin
				ctrl_r[7:0] <= wbDatI[7:0];
			end
			if (wbSel[1]) begin
				ctrl_r[15:8] <= wbDatI[15:8];
			end
		end
	end

	// ****************************************
	// Wishbone answer
	// ****************************************

	// One wait state; unmapped reads return zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			ack_r <= 1'h0;
			datO_r <= 32'h00000000;
		end else begin
			ack_r <= busReq;
			if (busReq && !wbWe) begin
				unique case (wbAdr[7:2])
					`LVD_IDX_CMD: datO_r <= cmd_r;
					`LVD_IDX_RDBK: datO_r <= {15'h0000, rdbkErr_r, rdbkData_r};
					`LVD_IDX_CTRL: datO_r <= {16'h0000, ctrl_r};
					default: datO_r <= 32'h00000000;
				endcase
			end
		end
	end
	assign wbAck = ack_r;
	assign wbDatO = datO_r;

	// ****************************************
	// Assertions
	// ****************************************
	AST_GAIN_NO_RECALC: assert property (@(posedge mclk) disable iff (srst)
		doWr && cmdType != LVD_TYPE_INPUT
		|=> corrReg_r[0][$past(cmdSlot)] == $past(corrReg_r[0][cmdSlot])
		&& corrReg_r[3][$past(cmdSlot)] == $past(corrReg_r[3][cmdSlot]))
		else $error("corrected code changed on coefficient write");
	AST_INPUT_ALL_CH: assert property (@(posedge mclk) disable iff (srst)
		doWr && trioHit && cmdType == LVD_TYPE_INPUT && cmdMask == 4'hf
		|=> inReg_r[0][$past(cmdSlot)] == $past(cmdData)
		&& inReg_r[3][$past(cmdSlot)] == $past(cmdData))
		else $error("multi-channel input write missed a channel");
	AST_GAIN_LSB: assert property (@(posedge mclk) disable iff (srst)
		doWr && trioHit && cmdType == LVD_TYPE_GAIN && cmdMask[1]
		|=> gainReg_r[1][$past(cmdSlot)] == {$past(cmdData[15:1]), 1'h0})
		else $error("gain register not 15 upper bits");
	AST_OFFSET_NO_COEF: assert property (@(posedge mclk) disable iff (srst)
		doWr && cmdAddr == `LVD_SET_OFFSET_DAC && cmdType != LVD_TYPE_INPUT
		|=> $stable(offsetDacCode) && rdbkErr_r)
		else $error("coefficient access reached offset DAC");
	AST_OFFSET_WRITE: assert property (@(posedge mclk) disable iff (srst)
		doWr && offHit |=> offsetDacCode == $past(cmdData) ##1 $stable(offsetDacCode) || wbAck)
		else $error("offset DAC input not loaded");
	AST_CLAMP_FV: assert property (@(posedge mclk) disable iff (srst)
		!ctrl_r[3] |=> cllCode[15:0] == $past(corrReg_r[0][`LVD_SLOT_CLL_CUR])
		&& clhCode[15:0] == $past(corrReg_r[0][`LVD_SLOT_CLH_CUR]))
		else $error("current clamp sets not loaded");
	AST_CLAMP_FI: assert property (@(posedge mclk) disable iff (srst)
		ctrl_r[7] |=> cllCode[31:16] == $past(corrReg_r[1][`LVD_SLOT_CLL_VOLT])
		&& clhCode[31:16] == $past(corrReg_r[1][`LVD_SLOT_CLH_VOLT]))
		else $error("voltage clamp sets not loaded");
	AST_READBACK: assert property (@(posedge mclk) disable iff (srst)
		doRd && trioHit && cmdType == LVD_TYPE_INPUT
		|=> rdbkData_r == $past(inReg_r[rdCh][cmdSlot]) && !rdbkErr_r)
		else $error("readback decode differs from write");
	AST_FIN_ADDR: assert property (@(posedge mclk) disable iff (srst)
		doWr && cmdAddr == 6'h09 && cmdType == LVD_TYPE_OFFS && cmdMask[2]
		|=> offsReg_r[2][1] == $past(cmdData))
		else $error("second force range set misdecoded");
	AST_SYS_TYPE: assert property (@(posedge mclk) disable iff (srst)
		doWr && cmdType == LVD_TYPE_SYS |=> rdbkErr_r ##1 !wbAck)
		else $error("type 00 reached a DAC register");
endmodule

//--- bench/lvd_host.sv
// Purpose: Host model that drives the level DAC register bank over classic Wishbone
// Assumes: Slave answers each single cycle by itself
// Notes: Lines it has released show inverted values, never the last ones
`timescale 1ns/10ps

module lvd_host import lvd_pkg::*; (
	input wire logic mclk,
	output logic wbCyc,
	output logic wbStb,
	output logic wbWe,
	output logic [7:0] wbAdr,
	output logic [3:0] wbSel,
	output logic [31:0] wbDatI,
	input wire logic [31:0] wbDatO,
	input wire logic wbAck
);
	// ****************************************
	// Bus cycles
	// ****************************************
	// Idle bus from time zero
	initial begin
		wbCyc = 1'h0;
		wbStb = 1'h0;
		wbWe = 1'h0;
		wbAdr = 8'h00;
		wbSel = 4'h0;
		wbDatI = 32'h00000000;
	end

	// One single cycle: request held until ack is sampled, then released
	task automatic busCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
			input logic [3:0] sel, output logic [31:0] rdat);
		@(posedge mclk);
		wbCyc <= 1'h1;
		wbStb <= 1'h1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= sel;
		wbDatI <= dat;
		do @(posedge mclk); while (wbAck !== 1'h1);
		rdat = wbDatO;
		wbCyc <= 1'h0;
		wbStb <= 1'h0;
		wbWe <= ~we;
		wbAdr <= ~adr;
		wbSel <= ~sel;
		wbDatI <= ~dat;
	endtask

	// Write cycle, read data dropped
	task automatic busWrite(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] unused;
		busCycle(1'h1, adr, dat, sel, unused);
	endtask

	// Read cycle with all byte lanes
	task automatic busRead(input logic [7:0] adr, output logic [31:0] dat);
		busCycle(1'h0, adr, 32'h00000000, 4'hf, dat);
	endtask

	// Command word: readback flag, channel mask, register type, set address, data
	task automatic sendCmd(input logic rd, input logic [3:0] m, input logic [1:0] t,
			input logic [5:0] a, input logic [15:0] d);
		busWrite(8'h00, {3'h0, rd, m, t, a, d}, 4'hf);
	endtask
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench of the level DAC register bank
// Assumes: Default coefficients pass the input code through unchanged
// Notes: Bench keeps its own copy of every trio and works out each output
`timescale 1ns/10ps
`include "lvd_cfg.svh"

module testbench import lvd_pkg::*; ;
	// ****************************************
	// Signals and model state
	// ****************************************
	logic mclk = 1'h0;
	logic srst = 1'h1;
	logic wbCyc, wbStb, wbWe, wbAck;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatI, wbDatO, w, w2, got;
	logic [63:0] finCode, cplCode, cphCode, cllCode, clhCode;
	logic [15:0] offsetDacCode, mOdac, mRd, mCtrl;
	logic [15:0] mIn [4][64], mGn [4][64], mOf [4][64], mCo [4][64];
	logic mErr;
	logic [31:0] mCmd; // Last command word the bench sent
	logic [2:0] b, i;
	int nFail = 0;
	int checksDone = 0;
	int seed = 32'h8c24f1b8;
	int k;
	localparam logic [28:0] CORNER [15] = '{
		{1'h0, 4'hf, 2'h3, 6'h0d, 16'h1234}, {1'h0, 4'h5, 2'h1, 6'h0d, 16'h7fff},
		{1'h1, 4'h4, 2'h1, 6'h0d, 16'h0000}, {1'h0, 4'h5, 2'h2, 6'h0d, 16'h9000},
		{1'h0, 4'h5, 2'h3, 6'h0d, 16'hffff}, {1'h1, 4'h1, 2'h3, 6'h0d, 16'h0000},
		{1'h0, 4'h2, 2'h3, 6'h00, 16'h5a5a}, {1'h0, 4'h1, 2'h1, 6'h00, 16'h1111},
		{1'h1, 4'h8, 2'h3, 6'h00, 16'h0000}, {1'h0, 4'hf, 2'h0, 6'h0d, 16'h2222},
		{1'h0, 4'h0, 2'h3, 6'h0d, 16'h3333}, {1'h0, 4'h3, 2'h3, 6'h22, 16'h4444},
		{1'h0, 4'h3, 2'h3, 6'h0e, 16'h4444}, {1'h1, 4'h2, 2'h2, 6'h10, 16'h0000},
		{1'h1, 4'h0, 2'h3, 6'h0d, 16'h0000}};

	// Free-running clock
	initial begin
		forever #5 mclk = ~mclk;
	end

	level_dac_register_addressing u_level_dac_register_addressing (.mclk(mclk), .srst(srst),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .finCode(finCode), .cplCode(cplCode),
		.cphCode(cphCode), .cllCode(cllCode), .clhCode(clhCode), .offsetDacCode(offsetDacCode));

	lvd_host u_lvd_host (.mclk(mclk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
		.wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck));

	// ****************************************
	// Expectation functions
	// ****************************************
	// Corrected code, clipped to the 16-bit range
	function automatic logic [15:0] corr(input logic [15:0] x, g, o);
		longint v;
		v = ((longint'(x) * (longint'(g) + 2)) >>> 16) + longint'(o) - 32768;
		if (v < 0) return 16'h0000;
		if (v > 65535) return 16'hffff;
		return v[15:0];
	endfunction

	// True when mask, type and set address name a real register
	function automatic logic hasTarget(input logic [3:0] m, input logic [1:0] t,
			input logic [5:0] a);
		if (m == 4'h0 || t == LVD_TYPE_SYS) return 1'h0;
		if (a == `LVD_SET_OFFSET_DAC) return t == LVD_TYPE_INPUT;
		if (a[5:3] >= 3'h1 && a[5:3] <= 3'h3) return a[2:0] <= 3'h5;
		if (a[5:3] == 3'h4 || a[5:3] == 3'h5) return a[2:0] <= 3'h1;
		return 1'h0;
	endfunction

	// ****************************************
	// Checking tasks
	// ****************************************
	// Compare and count
	task automatic cmp(input logic [31:0] seen, input logic [31:0] expv);
		checksDone++;
		if (seen !== expv) begin
			nFail++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
		end
	endtask

	// Send a command and mirror it in the model
	task automatic doCmd(input logic rd, input logic [3:0] m, input logic [1:0] t,
			input logic [5:0] a, input logic [15:0] d);
		int c;
		logic ok;
		ok = hasTarget(m, t, a);
		u_lvd_host.sendCmd(rd, m, t, a, d);
		mErr = !ok;
		mCmd = {3'h0, rd, m, t, a, d};
		// A readback with no target clears the readback data
		if (rd && !ok) mRd = 16'h0000;
		// Descending, so a readback ends on the lowest selected channel
		for (c = 3; c >= 0; c--) begin
			if (ok && m[c] && rd) begin
				mRd = (t == LVD_TYPE_GAIN) ? mGn[c][a] : (t == LVD_TYPE_OFFS) ? mOf[c][a] :
					(a == 6'h00) ? mOdac : mIn[c][a];
			end else if (ok && m[c]) begin
				if (a == 6'h00) mOdac = d;
				else if (t == LVD_TYPE_GAIN) mGn[c][a] = {d[15:1], 1'h0};
				else if (t == LVD_TYPE_OFFS) mOf[c][a] = d;
				else begin
					mIn[c][a] = d;
					mCo[c][a] = corr(d, mGn[c][a], mOf[c][a]);
				end
			end
		end
	endtask

	// Control word: force mode and current range per channel
	task automatic setCtrl(input logic [15:0] v);
		u_lvd_host.busWrite(8'h08, {16'h0000, v}, 4'hf);
		mCtrl = v;
	endtask

	// Model copy of every reset value
	task automatic resetModel();
		int j;
		for (j = 0; j < 256; j++) begin
			mIn[j / 64][j % 64] = `LVD_RST_INPUT;
			mGn[j / 64][j % 64] = `LVD_RST_GAIN;
			mOf[j / 64][j % 64] = `LVD_RST_OFFS;
			mCo[j / 64][j % 64] = `LVD_RST_CODE;
		end
		mOdac = `LVD_RST_CODE;
		mRd = 16'h0000;
		mCtrl = `LVD_RST_CTRL;
		mErr = 1'h0;
		mCmd = 32'h00000000;
	endtask

	// Let outputs settle, compare every code, then the readback word
	task automatic checkAll();
		int c;
		logic [3:0] n;
		logic [5:0] r;
		repeat (3) @(posedge mclk);
		for (c = 0; c < 4; c++) begin
			n = mCtrl[4 * c +: 4];
			r = n[3] ? ((n[2:0] > 3'h4) ? 6'h04 : {3'h0, n[2:0]}) : 6'h05;
			cmp(finCode[16 * c +: 16], mCo[c][`LVD_SET_FIN_BASE + r]);
			cmp(cplCode[16 * c +: 16], mCo[c][`LVD_SET_CPL_BASE + r]);
			cmp(cphCode[16 * c +: 16], mCo[c][`LVD_SET_CPH_BASE + r]);
			cmp(cllCode[16 * c +: 16], mCo[c][`LVD_SET_CLL_BASE + {5'h00, n[3]}]);
			cmp(clhCode[16 * c +: 16], mCo[c][`LVD_SET_CLH_BASE + {5'h00, n[3]}]);
		end
		cmp(offsetDacCode, mOdac);
		u_lvd_host.busRead(8'h04, got);
		cmp(got[16], mErr);
		cmp(got[15:0], mRd);
	endtask

	// Verdict and end of run
	task automatic wrapUp();
		if (nFail == 0 && checksDone > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		resetModel();
		repeat (10) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
		checkAll();
		// Hand-picked commands, reserved codes and coefficient cases
		for (k = 0; k < 15; k++) begin
			w = {3'h0, CORNER[k]};
			doCmd(w[28], w[27:24], w[23:22], w[21:16], w[15:0]);
			checkAll();
		end
		// Load an input register at every defined trio set address under a random channel mask, then walk all modes and ranges
		for (k = 8; k < 48; k++) begin
			w = $random(seed);
			if (k[2:0] < 3'h6 && (k < 32 || k[2:0] < 3'h2)) begin
				doCmd(1'h0, w[3:0], 2'h3, k[5:0], w[31:16]);
			end
		end
		for (k = 0; k < 8; k++) begin
			setCtrl({1'h1, k[2:0], 1'h0, k[2:0], 1'h1, k[2:0], 1'h1, 3'h7 - k[2:0]});
			checkAll();
		end
		// Random traffic within the map, with occasional mode changes
		for (k = 0; k < 150; k++) begin
			w = $random(seed);
			w2 = $random(seed);
			b = 3'h1 + (w[18:16] % 3'h5);
			i = (b > 3'h3) ? {2'h0, w[19]} : (w[22:20] % 3'h6);
			if (w[30:28] == 3'h0) setCtrl(w2[15:0]);
			else doCmd(w2[22] & w2[23], w2[19:16], w2[21:20],
				(w[25:23] == 3'h0) ? 6'h00 : {b, i}, w2[15:0]);
			checkAll();
		end
		// Mid-run reset drops coefficients, codes and control back to reset values
		@(posedge mclk);
		srst <= 1'h1;
		repeat (2) @(posedge mclk);
		srst <= 1'h0;
		resetModel();
		checkAll();
		// Partial-select command is dropped; unmapped word reads zero
		u_lvd_host.busWrite(8'h00, {8'h0f, 2'h3, 6'h0d, 16'hbeef}, 4'h7);
		checkAll();
		u_lvd_host.busRead(8'h00, got);
		cmp(got, mCmd);
		u_lvd_host.busRead(8'h08, got);
		cmp(got, {16'h0000, mCtrl});
		u_lvd_host.busRead(8'h3c, got);
		cmp(got, 32'h00000000);
		wrapUp();
	end

	// Hang guard, well beyond the expected run
	initial begin
		#200000;
		nFail++;
		wrapUp();
	end
endmodule
